// File: core/halt_wakeup_control.sv
// Halt entry, wakeup sources, start-up delay and clock gating
//
// Contract
// - Writing one to restart bit enters halt
// - Halted: all core clocks withheld, state frozen
// - Restart pin rising edge exits; not crystal
// - Port L wakeup event exits halt
// - Reset pin low exits halt, resets
// - Enabled brown-out exits halt by reset
// - Crystal wake: osc only, load FF, 256tc
// - Delay prescaler clocked by osc divided ten
// - Reset pin exit skips start-up delay
// - RC/external: no delay, watchdog still altered
// - Reset or brown-out exit fetches address zero
// - Pin edge or wakeup resumes next instruction
// - Crystal reset exit: accumulator, timer undefined; not flagged when the reset pin cuts a wakeup delay
// - Brown-out exit: registers and RAM unknown
// - Edge or wakeup exit keeps all state but the watchdog
// - Restart pin readable as input when running
// - Reset pin beats brown-out, cancels delay
`timescale 1ns/1ps

module halt_wakeup_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core side
  input wire logic halt_write,
  input wire logic miwu_wake,
  // Mask and clock options
  input wire hw_pkg::clk_opt_type clk_option,
  input wire logic bo_mask_en,
  // Pins and analog detector, asynchronous
  input wire logic halt_restart_pin,
  input wire logic reset_pin_n,
  input wire logic brownout_det,
  // Clock control
  output logic core_clk_en,
  output logic osc_en,
  output logic halted,
  // Core restart control
  output logic device_reset,
  output logic resume,
  output logic [15:0] restart_addr,
  // Status toward the core
  output logic restart_pin_level,
  output logic [7:0] wd_prescaler,
  output logic [7:0] wd_counter,
  output hw_pkg::cause_type exit_cause,
  output hw_pkg::loss_type state_loss
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] sync1_reg, sync1_next; // First stage, read only by stage two
  logic [2:0] sync2_reg, sync2_next; // Stable copies
  logic pin_prev_reg, pin_prev_next; // Restart pin, one cycle old

  // Shift the three pins in
  always_comb begin
    sync1_next = {brownout_det, reset_pin_n, halt_restart_pin};
    sync2_next = sync1_reg;
    pin_prev_next = sync2_reg[0];
  end

  // Register the synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 3'h2;
      sync2_reg <= 3'h2;
      pin_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      pin_prev_reg <= pin_prev_next;
    end
  end

  // ----------------------------------------
  // Wake decode
  // ----------------------------------------
  logic crystal;    // Crystal option, restart pin is an output
  logic pin_low;    // External reset held low
  logic bo_active;  // Brown-out seen with the option enabled
  logic pin_rise;   // Restart pin low to high
  logic wake_req;   // Combined non-reset wake request

  always_comb begin
    crystal = (clk_option == hw_pkg::CK_CRYSTAL);
    pin_low = ~sync2_reg[1];
    bo_active = bo_mask_en & sync2_reg[2];
    // Crystal drives the pin, so its edge means nothing
    pin_rise = sync2_reg[0] & ~pin_prev_reg & ~crystal;
    wake_req = pin_rise | miwu_wake;
  end

  // ----------------------------------------
  // Controller state and start-up timing
  // ----------------------------------------
  hw_pkg::state_type state_reg, state_next; // Controller state
  logic [3:0] tc_cnt_reg, tc_cnt_next; // Divider for the tc tick
  logic [7:0] pre_reg, pre_next; // Watchdog prescaler
  logic [7:0] cnt_reg, cnt_next; // Watchdog counter
  hw_pkg::cause_type cause_reg, cause_next; // Latched exit cause
  hw_pkg::loss_type loss_reg, loss_next; // Latched state loss
  logic tc_tick;          // One cycle per instruction cycle
  logic timeout;          // Start-up delay finished

  // Next state, delay counting and exit bookkeeping
  always_comb begin
    state_next = state_reg;
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    cause_next = cause_reg;
    loss_next = loss_reg;
    tc_tick = (tc_cnt_reg == hw_pkg::TC_DIV - 4'h1);
    timeout = tc_tick && (pre_reg == 8'h00);
    // Divider only runs during the delay
    tc_cnt_next = 4'h0;
    if (state_reg == hw_pkg::ST_START && !tc_tick) begin
      tc_cnt_next = tc_cnt_reg + 4'h1;
    end
    case (state_reg)
      hw_pkg::ST_RUN: begin
        if (halt_write) begin
          state_next = hw_pkg::ST_HALT;
          pre_next = hw_pkg::WD_LOAD;
          cnt_next = hw_pkg::WD_LOAD;
          cause_next = '0;
          loss_next = '0;
        end
      end
      hw_pkg::ST_HALT: begin
        // Reset pin first: it outranks brown-out
        if (pin_low) begin
          state_next = hw_pkg::ST_RUN;
          cause_next.reset_pin = 1'b1;
          loss_next.acc_timer = crystal;
          loss_next.wd_altered = 1'b1;
        end else if (bo_active) begin
          cause_next.brownout = 1'b1;
          loss_next.data_ram = 1'b1;
          loss_next.acc_timer = 1'b1;
          loss_next.wd_altered = 1'b1;
          pre_next = hw_pkg::WD_LOAD;
          cnt_next = hw_pkg::WD_LOAD;
          state_next = crystal ? hw_pkg::ST_START : hw_pkg::ST_RUN;
        end else if (wake_req) begin
          cause_next.restart_edge = pin_rise;
          cause_next.miwu = ~pin_rise & miwu_wake;
          loss_next.wd_altered = 1'b1;
          pre_next = hw_pkg::WD_LOAD;
          cnt_next = hw_pkg::WD_LOAD;
          // No delay without a crystal
          state_next = crystal ? hw_pkg::ST_START : hw_pkg::ST_WAKE;
        end
      end
      hw_pkg::ST_START: begin
        if (pin_low) begin
          // Delay abandoned, core goes straight to reset
          state_next = hw_pkg::ST_RUN;
          cause_next = '0;
          cause_next.reset_pin = 1'b1;
        end else begin
          // Supply drop during the delay turns it into a reset exit
          if (bo_active) begin
            cause_next.brownout = 1'b1;
            loss_next.data_ram = 1'b1;
            loss_next.acc_timer = 1'b1;
          end
          if (tc_tick) begin
            pre_next = pre_reg - 8'h01;
          end
          if (timeout) begin
            cnt_next = cnt_reg - 8'h01;
            state_next = cause_next.brownout ? hw_pkg::ST_RUN
                                            : hw_pkg::ST_WAKE;
          end
        end
      end
      hw_pkg::ST_WAKE: begin
        state_next = hw_pkg::ST_RUN;
      end
      default: begin
        state_next = hw_pkg::ST_RUN;
      end
    endcase
  end

  // Register controller state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= hw_pkg::ST_RUN;
      tc_cnt_reg <= 4'h0;
      pre_reg <= hw_pkg::WD_LOAD;
      cnt_reg <= hw_pkg::WD_LOAD;
      cause_reg <= '0;
      loss_reg <= '0;
    end else begin
      state_reg <= state_next;
      tc_cnt_reg <= tc_cnt_next;
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      cause_reg <= cause_next;
      loss_reg <= loss_next;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  logic clk_en_reg, clk_en_next; // Core clock gate enable
  logic osc_en_reg, osc_en_next; // Oscillator enable
  logic rst_out_reg, rst_out_next; // Reset toward the core
  logic resume_reg, resume_next; // One-cycle resume pulse
  logic [15:0] addr_reg, addr_next; // Restart fetch address
  logic level_reg, level_next; // Last level seen while running

  // Output decode from the next state; pin level from the current state
  always_comb begin
    // Enable is a flop: a latch gate downstream sees no glitch
    clk_en_next = (state_next == hw_pkg::ST_RUN) ||
                  (state_next == hw_pkg::ST_WAKE);
    osc_en_next = (state_next != hw_pkg::ST_HALT);
    // Brown-out holds reset through the crystal delay
    rst_out_next = pin_low || bo_active ||
                   (state_next == hw_pkg::ST_START &&
                    cause_next.brownout);
    resume_next = (state_next == hw_pkg::ST_WAKE);
    addr_next = addr_reg;
    if (rst_out_next) begin
      addr_next = hw_pkg::RESET_ADDR;
    end
    // Frozen while halted like every other core flop
    level_next = level_reg;
    if (state_reg == hw_pkg::ST_RUN) begin
      level_next = sync2_reg[0];
    end
  end

  // Register outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_en_reg <= 1'b1;
      osc_en_reg <= 1'b1;
      rst_out_reg <= 1'b0;
      resume_reg <= 1'b0;
      addr_reg <= hw_pkg::RESET_ADDR;
      level_reg <= 1'b0;
    end else begin
      clk_en_reg <= clk_en_next;
      osc_en_reg <= osc_en_next;
      rst_out_reg <= rst_out_next;
      resume_reg <= resume_next;
      addr_reg <= addr_next;
      level_reg <= level_next;
    end
  end

  // Drive the ports
  always_comb begin
    core_clk_en = clk_en_reg;
    osc_en = osc_en_reg;
    halted = (state_reg == hw_pkg::ST_HALT);
    device_reset = rst_out_reg;
    resume = resume_reg;
    restart_addr = addr_reg;
    restart_pin_level = level_reg;
    wd_prescaler = pre_reg;
    wd_counter = cnt_reg;
    exit_cause = cause_reg;
    state_loss = loss_reg;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  localparam int DLY_LAST = hw_pkg::STARTUP_CYCLES - 1; // Last delay cycle
  logic [11:0] start_cycles; // Cycles spent in the delay
  always_ff @(posedge clk) begin
    if (rst || state_reg != hw_pkg::ST_START) begin
      start_cycles <= 12'h000;
    end else begin
      start_cycles <= start_cycles + 12'h001;
    end
  end

  sequence wake_seq;
    (state_reg == hw_pkg::ST_WAKE && resume) ##1
    (state_reg == hw_pkg::ST_RUN && core_clk_en);
  endsequence

  halt_entry_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == hw_pkg::ST_RUN && halt_write |=>
    halted && !core_clk_en && wd_prescaler == 8'hff)
    else $error("halt not entered on write");
  clk_frozen_a: assert property (@(posedge clk) disable iff (rst)
    halted |-> !core_clk_en && !osc_en)
    else $error("clock running while halted");
  edge_wake_a: assert property (@(posedge clk) disable iff (rst)
    halted && pin_rise && !pin_low && !bo_active |=> wake_seq)
    else $error("restart edge did not resume");
  miwu_delay_a: assert property (@(posedge clk) disable iff (rst)
    halted && miwu_wake && crystal && !pin_low && !bo_active |=>
    state_reg == hw_pkg::ST_START && osc_en && !core_clk_en)
    else $error("crystal wakeup skipped start-up");
  pin_exit_a: assert property (@(posedge clk) disable iff (rst)
    halted && pin_low |=> device_reset && core_clk_en &&
    restart_addr == 16'h0000)
    else $error("reset pin exit wrong");
  bo_exit_a: assert property (@(posedge clk) disable iff (rst)
    halted && bo_active && !pin_low |=> device_reset &&
    exit_cause.brownout && state_loss.data_ram)
    else $error("brown-out exit wrong");
  delay_len_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == hw_pkg::ST_START && state_next == hw_pkg::ST_WAKE
    |-> start_cycles == 12'(DLY_LAST))
    else $error("start-up delay length wrong");
  rc_skip_a: assert property (@(posedge clk) disable iff (rst)
    halted && !crystal |=> state_reg != hw_pkg::ST_START)
    else $error("delay used without crystal");
  cancel_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == hw_pkg::ST_START && pin_low |=>
    state_reg == hw_pkg::ST_RUN && device_reset && exit_cause.reset_pin)
    else $error("reset pin did not cancel delay");
  resume_a: assert property (@(posedge clk) disable iff (rst)
    resume |-> !device_reset && !exit_cause.reset_pin &&
    !exit_cause.brownout)
    else $error("resume after reset exit");
  gpio_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == hw_pkg::ST_RUN |=> restart_pin_level ==
    $past(sync2_reg[0]))
    else $error("restart pin level not tracked");

endmodule

// File: core/hw_pkg.sv
// Shared types and constants for the halt and wakeup controller
package hw_pkg;

  // ----------------------------------------
  // Controller states, Gray coded on the path
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,  // Core clocks running
    ST_HALT  = 2'h1,  // All core clocks withheld
    ST_START = 2'h3,  // Oscillator only, start-up delay
    ST_WAKE  = 2'h2   // Clocks back, one-cycle resume
  } state_type;

  // ----------------------------------------
  // Clock source option
  // ----------------------------------------
  typedef enum logic [1:0] {
    CK_CRYSTAL = 2'h0,  // Two pin crystal or resonator
    CK_RC      = 2'h1,  // Single pin RC oscillator
    CK_EXT     = 2'h2   // External clock on input pin
  } clk_opt_type;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic reset_pin;    // Exit by external reset pin
    logic brownout;     // Exit by supply drop
    logic miwu;         // Exit by port L wakeup
    logic restart_edge; // Exit by restart pin rising edge
  } cause_type;

  typedef struct packed {
    logic acc_timer;    // Accumulator and timer undefined
    logic data_ram;     // Data registers and RAM unknown
    logic wd_altered;   // Watchdog prescaler/counter changed
  } loss_type;

  // ----------------------------------------
  // Values and timing
  // ----------------------------------------
  localparam logic [7:0] WD_LOAD = 8'hff;       // Prescaler/counter load
  localparam logic [15:0] RESET_ADDR = 16'h0000; // Fetch after reset
  localparam logic [3:0] TC_DIV = 4'ha;         // Osc clocks per tc
  localparam int STARTUP_TC = 256;              // Start-up delay in tc
  localparam int STARTUP_CYCLES = STARTUP_TC * int'(TC_DIV);

endpackage

// File: tb/halt_wakeup_control_test.sv
// Self-checking bench for the halt and wakeup controller
`timescale 1ns/1ps

module halt_wakeup_control_test;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk, rst, halt_write, miwu_wake, bo_mask_en;
  logic halt_restart_pin, reset_pin_n, brownout_det;
  hw_pkg::clk_opt_type clk_option;
  wire core_clk_en, osc_en, halted, device_reset, resume, restart_pin_level;
  wire [15:0] restart_addr;
  wire [7:0] wd_prescaler, wd_counter;
  hw_pkg::cause_type exit_cause;
  hw_pkg::loss_type state_loss;
  int n_mismatch = 0; // Mismatches seen
  int checked = 0; // Comparisons made
  int waited; // Edges spent in the last bounded wait

  halt_wakeup_control halt_wakeup_control_i (
    .clk(clk), .rst(rst), .halt_write(halt_write), .miwu_wake(miwu_wake),
    .clk_option(clk_option), .bo_mask_en(bo_mask_en),
    .halt_restart_pin(halt_restart_pin), .reset_pin_n(reset_pin_n),
    .brownout_det(brownout_det), .core_clk_en(core_clk_en), .osc_en(osc_en),
    .halted(halted), .device_reset(device_reset), .resume(resume),
    .restart_addr(restart_addr), .restart_pin_level(restart_pin_level),
    .wd_prescaler(wd_prescaler), .wd_counter(wd_counter),
    .exit_cause(exit_cause), .state_loss(state_loss));

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  // Compare and count; any unknown bit counts as a mismatch
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Selects the output a bounded wait is watching
  function automatic logic pick(input int w);
    case (w)
      0: pick = resume;
      1: pick = core_clk_en;
      default: pick = ~device_reset;
    endcase
  endfunction

  // Wait for an output under a bound; sampled 1 ns after each edge
  task automatic wait_sig(input int w, input int limit);
    waited = 0;
    while (pick(w) !== 1'b1 && waited < limit) begin
      @(posedge clk);
      #1;
      waited++;
    end
    check("wait_done", {15'h0, pick(w)}, 16'h1);
  endtask

  // Edges that carry stimulus, then settle
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle halt write, then the halted state is judged
  task automatic enter_halt;
    @(posedge clk) halt_write <= 1'b1;
    // Nothing follows the write for two cycles, as the two no-ops
    @(posedge clk) halt_write <= 1'b0;
    #1;
    check("halted", {15'h0, halted}, 16'h1);
    check("core_clk_en", {15'h0, core_clk_en}, 16'h0);
    check("osc_en", {15'h0, osc_en}, 16'h0);
    check("wd", {wd_prescaler, wd_counter}, {2{hw_pkg::WD_LOAD}});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Crystal wakeup: oscillator only for 256 tc of ten clocks each
  task automatic miwu_crystal;
    clk_option <= hw_pkg::CK_CRYSTAL;
    enter_halt();
    @(posedge clk) miwu_wake <= 1'b1;
    edges(100);
    check("osc_en", {15'h0, osc_en}, 16'h1);
    check("core_clk_en", {15'h0, core_clk_en}, 16'h0);
    wait_sig(0, 4000);
    check("delay", 16'(waited + 100), 16'(hw_pkg::STARTUP_CYCLES + 1));
    check("wd_counter", {8'h0, wd_counter}, 16'h00fe);
    check("device_reset", {15'h0, device_reset}, 16'h0);
    check("cause", {12'h0, exit_cause}, 16'h2);
    check("loss", {13'h0, state_loss}, 16'h1);
    @(posedge clk) miwu_wake <= 1'b0;
    edges(1);
    check("resume_end", {15'h0, resume}, 16'h0);
  endtask

  // RC clock: wakeup skips the delay yet alters the watchdog
  task automatic miwu_rc;
    clk_option <= hw_pkg::CK_RC;
    enter_halt();
    @(posedge clk) miwu_wake <= 1'b1;
    wait_sig(0, 4);
    check("loss", {13'h0, state_loss}, 16'h1);
    @(posedge clk) miwu_wake <= 1'b0;
    edges(1);
  endtask

  // External clock: restart pin edge resumes after halt
  task automatic edge_ext;
    clk_option <= hw_pkg::CK_EXT;
    enter_halt();
    @(posedge clk) halt_restart_pin <= 1'b1;
    wait_sig(0, 6);
    check("core_clk_en", {15'h0, core_clk_en}, 16'h1);
    check("cause", {12'h0, exit_cause}, 16'h1);
    check("loss", {13'h0, state_loss}, 16'h1);
    @(posedge clk) halt_restart_pin <= 1'b0;
    edges(4);
  endtask

  // Crystal: pin edge refused, pin frozen, reset pin exits at once
  task automatic reset_crystal;
    clk_option <= hw_pkg::CK_CRYSTAL;
    edges(4);
    check("pin_level", {15'h0, restart_pin_level}, 16'h0);
    enter_halt();
    @(posedge clk) halt_restart_pin <= 1'b1;
    edges(12);
    check("halted", {15'h0, halted}, 16'h1);
    check("pin_level", {15'h0, restart_pin_level}, 16'h0);
    @(posedge clk) reset_pin_n <= 1'b0;
    wait_sig(1, 5);
    check("device_reset", {15'h0, device_reset}, 16'h1);
    check("osc_en", {15'h0, osc_en}, 16'h1);
    check("restart_addr", restart_addr, hw_pkg::RESET_ADDR);
    check("cause", {12'h0, exit_cause}, 16'h8);
    check("acc_timer", {15'h0, state_loss.acc_timer}, 16'h1);
    @(posedge clk) reset_pin_n <= 1'b1;
    wait_sig(2, 6);
    edges(4);
    check("pin_level", {15'h0, restart_pin_level}, 16'h1);
    @(posedge clk) halt_restart_pin <= 1'b0;
    edges(4);
  endtask

  // Brown-out: masked off refused; crystal delay cut by reset pin
  task automatic brownout_crystal;
    clk_option <= hw_pkg::CK_CRYSTAL;
    bo_mask_en <= 1'b0;
    enter_halt();
    @(posedge clk) brownout_det <= 1'b1;
    edges(10);
    check("halted", {15'h0, halted}, 16'h1);
    @(posedge clk) bo_mask_en <= 1'b1;
    edges(200);
    check("osc_en", {15'h0, osc_en}, 16'h1);
    check("core_clk_en", {15'h0, core_clk_en}, 16'h0);
    check("device_reset", {15'h0, device_reset}, 16'h1);
    @(posedge clk) reset_pin_n <= 1'b0;
    wait_sig(1, 5);
    check("halted", {15'h0, halted}, 16'h0);
    check("cause", {12'h0, exit_cause}, 16'h8);
    check("device_reset", {15'h0, device_reset}, 16'h1);
    @(posedge clk) begin
      reset_pin_n <= 1'b1;
      brownout_det <= 1'b0;
    end
    wait_sig(2, 8);
  endtask

  // RC brown-out: reset at once, data marked lost, no resume
  task automatic brownout_rc;
    clk_option <= hw_pkg::CK_RC;
    enter_halt();
    @(posedge clk) brownout_det <= 1'b1;
    wait_sig(1, 5);
    check("device_reset", {15'h0, device_reset}, 16'h1);
    check("resume", {15'h0, resume}, 16'h0);
    check("data_ram", {15'h0, state_loss.data_ram}, 16'h1);
    check("restart_addr", restart_addr, hw_pkg::RESET_ADDR);
    @(posedge clk) brownout_det <= 1'b0;
    wait_sig(2, 8);
  endtask

  // ----------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    halt_write = 1'b0;
    miwu_wake = 1'b0;
    bo_mask_en = 1'b0;
    halt_restart_pin = 1'b0;
    reset_pin_n = 1'b1;
    brownout_det = 1'b0;
    clk_option = hw_pkg::CK_CRYSTAL;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    edges(3);
    miwu_crystal();
    miwu_rc();
    edge_ext();
    reset_crystal();
    brownout_crystal();
    brownout_rc();
    report_and_stop();
  end

  // Whole run needs near 2900 edges; cut off well past that
  initial begin
    #80000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
